// File: isp_set_pending.sv
`timescale 1ns/10ps
module isp_set_pending (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] src_enable,
    input  wire logic [31:0] src_raise,
    input  wire logic [31:0] src_active,
    output logic      [31:0] pend_out,
    output logic      [31:0] clear_strobe,
    output logic             irq
);
    import isp_pkg::*;

    function automatic logic reg_hit(input logic [3:0] a,
                                     input logic [3:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // ************************************************
    // bus handshake
    // ************************************************
    // one wait cycle so read data always comes from a flop
    isp_bus_t          bus_q;
    logic              req;
    logic              take;
    logic              wr_take;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic [31:0]       byte_mask;
    logic [31:0]       wdata_m;
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & (bus_q == ISP_BUS_IDLE);
    assign take            = req & (bus_q == ISP_BUS_ANSWER);
    assign wr_take         = avs_write & take;
    assign avs_readdata    = rdata_q;
    assign byte_mask       = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata_m         = avs_writedata & byte_mask;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus_q <= ISP_BUS_IDLE;
        end else begin
            case (bus_q)
                ISP_BUS_IDLE:   bus_q <= req ? ISP_BUS_ANSWER : ISP_BUS_IDLE;
                ISP_BUS_ANSWER: bus_q <= ISP_BUS_IDLE;
                default:        bus_q <= ISP_BUS_IDLE;
            endcase
        end
    end

    // ************************************************
    // set and clear decode
    // ************************************************
    logic        wr_set;
    logic        wr_clr;
    logic        wr_stat;
    logic        wr_mask;
    logic [31:0] pend_q;
    logic [31:0] ones_v;
    logic [31:0] force_v;
    logic [31:0] clear_v;
    logic [31:0] refused_v;
    assign wr_set    = wr_take & reg_hit(avs_address, ISP_OFS_SET);
    assign wr_clr    = wr_take & reg_hit(avs_address, ISP_OFS_CLR);
    assign wr_stat   = wr_take & reg_hit(avs_address, ISP_OFS_STAT);
    assign wr_mask   = wr_take & reg_hit(avs_address, ISP_OFS_MASK);
    // unimplemented bits 27, 26, 3, 1, 0 never reach a flag
    assign ones_v    = wr_set ? (wdata_m & ISP_IMPL_MASK) : 32'h0;
    // zeros and already pending or disabled sources are left alone
    assign force_v   = ones_v & src_enable & ~pend_q;
    assign refused_v = ones_v & ~src_enable & ~pend_q;
    // an interrupt being serviced keeps its pending bit
    assign clear_v   = wr_clr ? (wdata_m & ISP_IMPL_MASK & ~src_active)
                              : 32'h0;

    isp_pend_bank #(
        .W          (32)
    ) u_bank (
        .core_clk   (core_clk),
        .reset      (reset),
        .impl       (ISP_IMPL_MASK),
        .force_set  (force_v),
        .src_raise  (src_raise),
        .clear_set  (clear_v),
        .pend_q     (pend_q)
    );
    assign pend_out = pend_q;

    // ************************************************
    // events, status and mask
    // ************************************************
    logic [ISP_EV_NUM-1:0] ev;
    logic [ISP_EV_NUM-1:0] stat_q;
    logic [ISP_EV_NUM-1:0] stat_d;
    logic [ISP_EV_NUM-1:0] mask_q;
    logic [31:0]           clr_str_q;
    assign ev[ISP_EV_TAKEN]   = |force_v;
    assign ev[ISP_EV_REFUSED] = |refused_v;
    // a new event beats a write-one-to-clear in the same cycle
    assign stat_d = (stat_q & ~(wr_stat ? wdata_m[ISP_EV_NUM-1:0]
                                        : ISP_STAT_RST)) | ev;
    assign irq          = |(stat_q & mask_q);
    assign clear_strobe = clr_str_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stat_q    <= ISP_STAT_RST;
            mask_q    <= ISP_MASK_RST;
            clr_str_q <= 32'h0;
        end else begin
            stat_q    <= stat_d;
            clr_str_q <= clear_v;
            if (wr_mask) begin
                mask_q <= wdata_m[ISP_EV_NUM-1:0];
            end
        end
    end

    // ************************************************
    // read data
    // ************************************************
    logic [31:0] pend_rd;
    // both set and clear addresses show the live pending flags
    assign pend_rd = pend_q & ISP_IMPL_MASK;
    assign rdata_d =
        reg_hit(avs_address, ISP_OFS_SET)  ? pend_rd :
        reg_hit(avs_address, ISP_OFS_CLR)  ? pend_rd :
        reg_hit(avs_address, ISP_OFS_STAT) ? {30'h0, stat_q} :
        reg_hit(avs_address, ISP_OFS_MASK) ? {30'h0, mask_q} : 32'h0;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 32'h0;
        end else if (avs_read && avs_waitrequest) begin
            rdata_q <= rdata_d;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    set_forces_a: assert property (
        wr_set && src_raise == 32'h0 && clear_v == 32'h0
        |=> pend_q == $past(pend_q | (wdata_m & ISP_IMPL_MASK & src_enable)))
        else $error("set write did not pend the written bits");
    disabled_kept_a: assert property (
        wr_set && src_raise == 32'h0
        |=> (pend_q & $past(~src_enable & ~pend_q)) == 32'h0)
        else $error("write pended a disabled source");
    read_live_a: assert property (
        avs_read && !avs_waitrequest && reg_hit(avs_address, ISP_OFS_SET)
        |-> avs_readdata == ($past(pend_q) & ISP_IMPL_MASK))
        else $error("set register read is not the pending state");
    set_no_clear_a: assert property (
        !wr_clr |=> ($past(pend_q) & ~pend_q) == 32'h0)
        else $error("pending bit dropped without a clear write");
    clear_works_a: assert property (
        clear_v != 32'h0 && src_raise == 32'h0 && !wr_set
        |=> (pend_q & $past(clear_v)) == 32'h0
            && clear_strobe == $past(clear_v))
        else $error("clear write did not clear the pending bit");
    upper_map_a: assert property (
        wr_set && wdata_m[31] && src_enable[31] |=> pend_out[31])
        else $error("bit 31 did not pend interrupt 63");
    middle_map_a: assert property (
        wr_set && wdata_m[4] && src_enable[4] ##1 (!wr_clr)[*2]
        |-> pend_out[4])
        else $error("bit 4 did not pend interrupt 36");
    gaps_zero_a: assert property (
        avs_read && !avs_waitrequest && reg_hit(avs_address, ISP_OFS_SET)
        |-> avs_readdata[27:26] == 2'h0 && avs_readdata[1:0] == 2'h0)
        else $error("unimplemented bit read as one");
    irq_follows_a: assert property (
        ev[ISP_EV_TAKEN] && mask_q[ISP_EV_TAKEN] && !wr_mask |=> irq)
        else $error("unmasked event did not raise irq");

    // ************************************************
    // status and mapping checks
    // ************************************************
    // a zero write must leave every flag exactly as it was
    zero_write_a: assert property (
        wr_set && wdata_m == 32'h0 && src_raise == 32'h0
        |=> pend_q == $past(pend_q))
        else $error("zero write changed the pending flags");
    event_sticky_a: assert property (
        ev != ISP_STAT_RST |=> (stat_q & $past(ev)) == $past(ev))
        else $error("event did not set its status bit");
    status_held_a: assert property (
        !wr_stat |=> ($past(stat_q) & ~stat_q) == ISP_STAT_RST)
        else $error("status bit dropped without a clear write");
    // clearing a serviced interrupt would lose it, so it is kept
    active_kept_a: assert property (
        wr_clr
        |=> ($past(pend_q & src_active) & ~pend_q) == 32'h0)
        else $error("clear write dropped a serviced interrupt");
    gap_bits_a: assert property (
        (pend_out & ~ISP_IMPL_MASK) == 32'h0)
        else $error("unimplemented pending bit set");
    high_map_a: assert property (
        wr_set && wdata_m[28] && src_enable[28] |=> pend_out[28])
        else $error("bit 28 did not pend interrupt 60");
    low_map_a: assert property (
        wr_set && wdata_m[2] && src_enable[2] |=> pend_out[2])
        else $error("bit 2 did not pend interrupt 34");
    // masters may rely on exactly one wait state per access
    wait_once_a: assert property (
        avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");

    force_seen_c:  cover property (wr_set && force_v != 32'h0);
    refuse_seen_c: cover property (wr_set && refused_v != 32'h0);
    clear_seen_c:  cover property (wr_clr ##1 clear_strobe != 32'h0);
    irq_seen_c:    cover property ($rose(irq));
    refuse_irq_c:  cover property (mask_q[ISP_EV_REFUSED] && irq);
endmodule : isp_set_pending

// File: isp_pkg.sv
`timescale 1ns/10ps
package isp_pkg;
    // ************************************************
    // register map, byte addresses
    // ************************************************
    localparam logic [3:0]  ISP_OFS_SET    = 4'h0;
    localparam logic [3:0]  ISP_OFS_CLR    = 4'h4;
    localparam logic [3:0]  ISP_OFS_STAT   = 4'h8;
    localparam logic [3:0]  ISP_OFS_MASK   = 4'hc;
    // ************************************************
    // fields and reset values
    // ************************************************
    localparam logic [31:0] ISP_IMPL_MASK  = 32'hf3fffff4;
    localparam int          ISP_IRQ_BASE   = 32;
    localparam logic [31:0] ISP_PEND_RST   = 32'h0000_0000;
    localparam logic [1:0]  ISP_STAT_RST   = 2'h0;
    localparam logic [1:0]  ISP_MASK_RST   = 2'h0;
    localparam int          ISP_EV_TAKEN   = 0;
    localparam int          ISP_EV_REFUSED = 1;
    localparam int          ISP_EV_NUM     = 2;
    typedef enum logic [0:0] {
        ISP_BUS_IDLE,
        ISP_BUS_ANSWER
    } isp_bus_t;
endpackage : isp_pkg

module isp_pend_bank #(
    parameter int W = 32
) (
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire logic [W-1:0]  impl,
    input  wire logic [W-1:0]  force_set,
    input  wire logic [W-1:0]  src_raise,
    input  wire logic [W-1:0]  clear_set,
    output logic      [W-1:0]  pend_q
);
    import isp_pkg::*;
    // ************************************************
    // pending flags
    // ************************************************
    logic [W-1:0] pend_d;
    // a source raising in the clear cycle wins over the clear
    assign pend_d = ((pend_q & ~clear_set) | force_set | src_raise) & impl;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_q <= W'(ISP_PEND_RST);
        end else begin
            pend_q <= pend_d;
        end
    end
endmodule : isp_pend_bank

// File: test_interrupt_set_pending_upper.sv
`timescale 1ns/10ps
module test_interrupt_set_pending_upper;
    import isp_pkg::*;
    logic        core_clk, reset, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, src_enable, src_raise;
    logic [31:0] src_active, pend_out, clear_strobe, q, pe, d, cl, en, act;
    logic [1:0]  st;
    int          err_count, checks_done;

    isp_set_pending isp_set_pending_inst (
        .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .src_enable(src_enable), .src_raise(src_raise),
        .src_active(src_active), .pend_out(pend_out),
        .clear_strobe(clear_strobe), .irq(irq));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ********************************
    // bus and checking tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // pending state after a set write, from the rules
    function automatic logic [31:0] set_effect(input logic [31:0] p,
                                               input logic [31:0] wd,
                                               input logic [31:0] e);
        set_effect = p | (wd & e & ISP_IMPL_MASK);
    endfunction : set_effect

    // bits a clear write removes: serviced ones are kept
    function automatic logic [31:0] clr_effect(input logic [31:0] wd,
                                               input logic [31:0] a);
        clr_effect = wd & ~a & ISP_IMPL_MASK;
    endfunction : clr_effect

    task automatic finish_test;
        $display("errors=%0d checks=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // holds the request until waitrequest is seen low, no fixed latency
    task automatic acc(input logic wr, input logic [3:0] a,
                       input logic [31:0] dd);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= dd;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        #1;
    endtask : acc

    initial begin
        #100000;
        err_count++;
        finish_test();
    end

    // ********************************
    // test sequence
    // ********************************
    initial begin
        err_count = 0;
        checks_done = 0;
        reset = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        {src_enable, src_raise, src_active} = '0;
        void'($urandom(32'h941a));
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        pe = '0;
        st = '0;
        acc(1'b0, ISP_OFS_SET, 32'h0);
        check(q, 32'h0);
        acc(1'b1, ISP_OFS_MASK, 32'h1);
        @(posedge core_clk);
        src_enable <= 32'hffffffff;
        acc(1'b1, ISP_OFS_SET, 32'hffffffff);
        check(pend_out, ISP_IMPL_MASK);
        check(irq, 32'h1);
        acc(1'b1, ISP_OFS_STAT, 32'h3);
        acc(1'b1, ISP_OFS_SET, 32'hffffffff);
        acc(1'b1, ISP_OFS_SET, 32'h0);
        check(pend_out, ISP_IMPL_MASK);
        check(irq, 32'h0);
        acc(1'b1, ISP_OFS_CLR, 32'hffffffff);
        check(clear_strobe, ISP_IMPL_MASK);
        // random sets and clears against a bench model of pending state
        repeat (12) begin
            en = $urandom;
            act = $urandom;
            @(posedge core_clk);
            src_enable <= en;
            src_active <= act;
            d = $urandom;
            acc(1'b1, ISP_OFS_SET, d);
            st |= {|(d & ~en & ~pe & ISP_IMPL_MASK),
                   |(d & en & ~pe & ISP_IMPL_MASK)};
            pe = set_effect(pe, d, en);
            acc(1'b0, ISP_OFS_SET, 32'h0);
            check(q, pe);
            d = $urandom;
            acc(1'b1, ISP_OFS_CLR, d);
            cl = clr_effect(d, act);
            check(clear_strobe, cl);
            pe &= ~cl;
            acc(1'b0, ISP_OFS_CLR, 32'h0);
            check(q, pe);
            acc(1'b0, ISP_OFS_STAT, 32'h0);
            check(q, {30'h0, st});
            check(irq, {31'h0, st[0]});
        end
        // hardware requests show up live in the read value
        d = $urandom;
        @(posedge core_clk);
        src_raise <= d;
        pe |= d & ISP_IMPL_MASK;
        acc(1'b0, ISP_OFS_SET, 32'h0);
        check(q, pe);
        @(posedge core_clk);
        src_raise <= 32'h0;
        acc(1'b0, 4'h2, 32'h0);
        check(q, 32'h0);
        acc(1'b1, 4'h2, 32'hffffffff);
        acc(1'b1, ISP_OFS_STAT, 32'h3);
        check(pend_out, pe);
        check(irq, 32'h0);
        // lane enables and the refused-event interrupt
        @(posedge core_clk);
        src_enable     <= 32'h0;
        src_active     <= 32'h0;
        acc(1'b1, ISP_OFS_CLR, 32'hffffffff);
        check(pend_out, 32'h0);
        acc(1'b1, ISP_OFS_MASK, 32'h2);
        @(posedge core_clk);
        avs_byteenable <= 4'h2;
        acc(1'b1, ISP_OFS_SET, 32'hffffffff);
        check(pend_out, 32'h0);
        check(irq, 32'h1);
        @(posedge core_clk);
        src_enable     <= 32'hffffffff;
        acc(1'b1, ISP_OFS_SET, 32'hffffffff);
        pe = set_effect(32'h0, 32'h0000ff00, 32'hffffffff);
        check(pend_out, pe);
        @(posedge core_clk);
        avs_byteenable <= 4'hf;
        acc(1'b1, ISP_OFS_STAT, 32'h2);
        check(irq, 32'h0);
        acc(1'b0, ISP_OFS_STAT, 32'h0);
        check(q, 32'h1);
        finish_test();
    end
endmodule : test_interrupt_set_pending_upper
